// ### core/pack_extend_consts.vh
// constants for the pack and extend datapath
`ifndef PACK_EXTEND_CONSTS_VH
`define PACK_EXTEND_CONSTS_VH

`define OP_WIDTH                 4
`define OP_PACK_LOW_HIGH         4'h0
`define OP_PACK_HIGH_LOW         4'h1
`define OP_SIGN_WIDEN_BYTE       4'h2
`define OP_SIGN_WIDEN_HALF       4'h3
`define OP_SIGN_WIDEN_DUAL       4'h4
`define OP_ZERO_WIDEN_BYTE       4'h5
`define OP_ZERO_WIDEN_HALF       4'h6
`define OP_ZERO_WIDEN_DUAL       4'h7
`define OP_SIGN_WIDEN_BYTE_ADD   4'h8
`define OP_SIGN_WIDEN_HALF_ADD   4'h9
`define OP_SIGN_WIDEN_DUAL_ADD   4'ha
`define OP_ZERO_WIDEN_BYTE_ADD   4'hb
`define OP_ZERO_WIDEN_HALF_ADD   4'hc
`define OP_ZERO_WIDEN_DUAL_ADD   4'hd

`define ROT_WIDTH                2
`define SHIFT_WIDTH              5
`define DEST_WIDTH               4
`define RESULT_RESET             32'h0000_0000

`endif

// ### core/pack_extend_datapath.v
// single-cycle pack, widen and widen-add execute unit
`timescale 1ns/10ps
`include "pack_extend_consts.vh"

module pack_extend_datapath #(
  parameter DATA_WIDTH = 32
) (
  input  wire                    clk_i,
  input  wire                    resetn_i,
  input  wire                    issue_i,
  input  wire [`OP_WIDTH-1:0]    op_i,
  input  wire [`ROT_WIDTH-1:0]   rotate_right_option_i,
  input  wire [`SHIFT_WIDTH-1:0] shift_amount_i,
  input  wire [DATA_WIDTH-1:0]   first_operand_register_i,
  input  wire [DATA_WIDTH-1:0]   second_operand_register_i,
  input  wire [`DEST_WIDTH-1:0]  dest_index_i,
  input  wire                    cond_pass_i,
  output reg                     write_en_o,
  output reg  [`DEST_WIDTH-1:0]  write_index_o,
  output reg  [DATA_WIDTH-1:0]   result_o,
  output reg                     flags_write_o
);

  // rotate right by a whole number of bytes
  function [31:0] rotate_bytes;
    input [31:0] value;
    input [1:0]  sel;
    begin
      case (sel)
        2'h1:    rotate_bytes = {value[7:0], value[31:8]};
        2'h2:    rotate_bytes = {value[15:0], value[31:16]};
        2'h3:    rotate_bytes = {value[23:0], value[31:24]};
        default: rotate_bytes = value;
      endcase
    end
  endfunction

  // byte to halfword, signed or zero fill
  function [15:0] widen_byte16;
    input [7:0] b;
    input       signed_form;
    begin
      widen_byte16 = {{8{signed_form & b[7]}}, b};
    end
  endfunction

  // byte to word, signed or zero fill
  function [31:0] widen_byte32;
    input [7:0] b;
    input       signed_form;
    begin
      widen_byte32 = {{24{signed_form & b[7]}}, b};
    end
  endfunction

  // halfword to word, signed or zero fill
  function [31:0] widen_half32;
    input [15:0] h;
    input        signed_form;
    begin
      widen_half32 = {{16{signed_form & h[15]}}, h};
    end
  endfunction

  // one 16-bit lane sum, carry out dropped so lanes stay apart
  function [15:0] lane_add16;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] full;
    begin
      full       = {1'h0, a} + {1'h0, b};
      lane_add16 = full[15:0];
    end
  endfunction

  // word sum, wraps with no saturation
  function [31:0] word_add32;
    input [31:0] a;
    input [31:0] b;
    reg   [32:0] full;
    begin
      full       = {1'h0, a} + {1'h0, b};
      word_add32 = full[31:0];
    end
  endfunction

  // low half from the first operand, high half from the shifted second
  function [31:0] pack_low_high;
    input [31:0] first;
    input [31:0] second_shifted;
    begin
      pack_low_high = {second_shifted[31:16], first[15:0]};
    end
  endfunction

  // high half from the first operand, low half from the shifted second
  function [31:0] pack_high_low;
    input [31:0] first;
    input [31:0] second_shifted;
    begin
      pack_high_low = {first[31:16], second_shifted[15:0]};
    end
  endfunction

  // arithmetic shift amount, a zero field standing for 32
  function [5:0] asr_field;
    input [4:0] field;
    begin
      if (field == 5'h00) begin
        asr_field = 6'h20;
      end else begin
        asr_field = {1'h0, field};
      end
    end
  endfunction

  // opcodes past the last defined one are refused
  function op_is_valid;
    input [`OP_WIDTH-1:0] op;
    begin
      op_is_valid = (op <= `OP_ZERO_WIDEN_DUAL_ADD);
    end
  endfunction

  // signed forms of the widen and widen-add groups
  function op_is_signed;
    input [`OP_WIDTH-1:0] op;
    begin
      case (op)
        `OP_SIGN_WIDEN_BYTE:     op_is_signed = 1'h1;
        `OP_SIGN_WIDEN_HALF:     op_is_signed = 1'h1;
        `OP_SIGN_WIDEN_DUAL:     op_is_signed = 1'h1;
        `OP_SIGN_WIDEN_BYTE_ADD: op_is_signed = 1'h1;
        `OP_SIGN_WIDEN_HALF_ADD: op_is_signed = 1'h1;
        `OP_SIGN_WIDEN_DUAL_ADD: op_is_signed = 1'h1;
        default:                 op_is_signed = 1'h0;
      endcase
    end
  endfunction

  // widen-add forms
  function op_adds;
    input [`OP_WIDTH-1:0] op;
    begin
      case (op)
        `OP_SIGN_WIDEN_BYTE_ADD: op_adds = 1'h1;
        `OP_SIGN_WIDEN_HALF_ADD: op_adds = 1'h1;
        `OP_SIGN_WIDEN_DUAL_ADD: op_adds = 1'h1;
        `OP_ZERO_WIDEN_BYTE_ADD: op_adds = 1'h1;
        `OP_ZERO_WIDEN_HALF_ADD: op_adds = 1'h1;
        `OP_ZERO_WIDEN_DUAL_ADD: op_adds = 1'h1;
        default:                 op_adds = 1'h0;
      endcase
    end
  endfunction

  // operand shape classes
  localparam SHAPE_BYTE    = 3'h0;
  localparam SHAPE_HALF    = 3'h1;
  localparam SHAPE_DUAL    = 3'h2;
  localparam SHAPE_PACK_LH = 3'h3;
  localparam SHAPE_PACK_HL = 3'h4;
  localparam SHAPE_NONE    = 3'h5;

  // operand shape class of each opcode
  function [2:0] op_shape;
    input [`OP_WIDTH-1:0] op;
    begin
      case (op)
        `OP_PACK_LOW_HIGH:       op_shape = SHAPE_PACK_LH;
        `OP_PACK_HIGH_LOW:       op_shape = SHAPE_PACK_HL;
        `OP_SIGN_WIDEN_BYTE:     op_shape = SHAPE_BYTE;
        `OP_SIGN_WIDEN_HALF:     op_shape = SHAPE_HALF;
        `OP_SIGN_WIDEN_DUAL:     op_shape = SHAPE_DUAL;
        `OP_ZERO_WIDEN_BYTE:     op_shape = SHAPE_BYTE;
        `OP_ZERO_WIDEN_HALF:     op_shape = SHAPE_HALF;
        `OP_ZERO_WIDEN_DUAL:     op_shape = SHAPE_DUAL;
        `OP_SIGN_WIDEN_BYTE_ADD: op_shape = SHAPE_BYTE;
        `OP_SIGN_WIDEN_HALF_ADD: op_shape = SHAPE_HALF;
        `OP_SIGN_WIDEN_DUAL_ADD: op_shape = SHAPE_DUAL;
        `OP_ZERO_WIDEN_BYTE_ADD: op_shape = SHAPE_BYTE;
        `OP_ZERO_WIDEN_HALF_ADD: op_shape = SHAPE_HALF;
        `OP_ZERO_WIDEN_DUAL_ADD: op_shape = SHAPE_DUAL;
        default:                 op_shape = SHAPE_NONE;
      endcase
    end
  endfunction

  wire [31:0] rotated;
  wire [31:0] shifted_left;
  wire [5:0]  asr_amount;
  wire [31:0] shifted_right;
  wire        op_valid;
  wire        widen_signed;
  wire        widen_add;
  wire [2:0]  shape;
  wire [31:0] widened_byte;
  wire [31:0] widened_half;
  wire [15:0] dual_low;
  wire [15:0] dual_high;
  wire [31:0] widened_dual;
  wire [31:0] sum_byte;
  wire [31:0] sum_half;
  wire [15:0] sum_dual_low;
  wire [15:0] sum_dual_high;
  wire [31:0] sum_dual;
  wire [31:0] packed_low_high;
  wire [31:0] packed_high_low;
  wire        next_write_en;
  reg  [31:0] next_result;

  assign op_valid     = op_is_valid(op_i);
  assign widen_signed = op_is_signed(op_i);
  assign widen_add    = op_adds(op_i);
  assign shape        = op_shape(op_i);

  assign rotated = rotate_bytes(second_operand_register_i, rotate_right_option_i);

  // pack operand shifts
  assign shifted_left    = second_operand_register_i << shift_amount_i;
  // a shift of 32 fills the whole word with the sign bit
  assign asr_amount      = asr_field(shift_amount_i);
  assign shifted_right   = $signed(second_operand_register_i) >>> asr_amount;
  assign packed_low_high = pack_low_high(first_operand_register_i, shifted_left);
  assign packed_high_low = pack_high_low(first_operand_register_i, shifted_right);

  // widened forms of the rotated second operand
  assign widened_byte = widen_byte32(rotated[7:0], widen_signed);
  assign widened_half = widen_half32(rotated[15:0], widen_signed);
  assign dual_low     = widen_byte16(rotated[7:0], widen_signed);
  assign dual_high    = widen_byte16(rotated[23:16], widen_signed);
  assign widened_dual = {dual_high, dual_low};

  // sums against the first operand
  assign sum_byte      = word_add32(first_operand_register_i, widened_byte);
  assign sum_half      = word_add32(first_operand_register_i, widened_half);
  assign sum_dual_low  = lane_add16(first_operand_register_i[15:0], dual_low);
  assign sum_dual_high = lane_add16(first_operand_register_i[31:16], dual_high);
  assign sum_dual      = {sum_dual_high, sum_dual_low};

  assign next_write_en = issue_i & cond_pass_i & op_valid;

  always @* begin
    case (shape)
      SHAPE_BYTE: begin
        if (widen_add) begin
          next_result = sum_byte;
        end else begin
          next_result = widened_byte;
        end
      end
      SHAPE_HALF: begin
        if (widen_add) begin
          next_result = sum_half;
        end else begin
          next_result = widened_half;
        end
      end
      SHAPE_DUAL: begin
        if (widen_add) begin
          next_result = sum_dual;
        end else begin
          next_result = widened_dual;
        end
      end
      SHAPE_PACK_LH: begin
        next_result = packed_low_high;
      end
      SHAPE_PACK_HL: begin
        next_result = packed_high_low;
      end
      default: begin
        next_result = `RESULT_RESET;
      end
    endcase
  end

  // only the output stage holds state; flags_write_o is always driven low
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_en_o    <= 1'h0;
      write_index_o <= {`DEST_WIDTH{1'h0}};
      result_o      <= `RESULT_RESET;
      flags_write_o <= 1'h0;
    end else begin
      write_en_o    <= next_write_en;
      write_index_o <= dest_index_i;
      result_o      <= next_result;
      flags_write_o <= 1'h0;
    end
  end

endmodule

// ### tb/pack_extend_assertions.sv
// port checks for the pack and widen unit
`timescale 1ns/10ps
module pack_extend_assertions (
  input wire logic        clk_i, resetn_i, issue_i, cond_pass_i, write_en_o, flags_write_o,
  input wire logic [3:0]  op_i,
  input wire logic [31:0] first_operand_register_i, result_o
);
  logic [31:0] f_q;
  always_ff @(posedge clk_i) f_q <= first_operand_register_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence go_s; issue_i && cond_pass_i && op_i < 4'he; endsequence
  a_write_go: assert property (go_s |=> write_en_o) else $error("no write");
  a_no_write: assert property (!cond_pass_i |=> !write_en_o) else $error("stray write");
  a_bad_op: assert property (op_i > 4'hd |=> !write_en_o && !result_o) else $error("bad op");
  a_flags_kept: assert property (!flags_write_o) else $error("flags");
  a_low_kept: assert property (op_i == 4'h0 |=> result_o[15:0] == f_q[15:0]) else $error("low");
  a_high_kept: assert property (op_i == 4'h1 |=> result_o[31:16] == f_q[31:16]) else $error("high");
  a_byte_zero: assert property (op_i == 4'h5 |=> !result_o[31:8]) else $error("byte");
  a_dual_zero: assert property (op_i == 4'h7 |=> !result_o[31:24] && !result_o[15:8]) else $error("dual");
endmodule

// ### tb/decode_model.sv
// decode stage stand-in, one op per call
`timescale 1ns/10ps
module decode_model (
  output logic        issue_i, cond_pass_i,
  output logic [3:0]  op_i, dest_index_i,
  output logic [1:0]  rotate_right_option_i,
  output logic [4:0]  shift_amount_i,
  output logic [31:0] first_operand_register_i, second_operand_register_i
);
  initial issue_i = 1'b0;
  task automatic put(logic [3:0] o, logic [1:0] n, logic [4:0] s, logic [31:0] x, y, logic c);
    {issue_i, cond_pass_i, op_i, dest_index_i} = {1'b1, c, o, 1'b0, o[2:0]};
    {rotate_right_option_i, shift_amount_i, first_operand_register_i, second_operand_register_i} = {n, s, x, y};
  endtask
  task automatic idle(logic [3:0] o);
    {issue_i, cond_pass_i, op_i} = {1'b0, 1'b1, o};
  endtask
endmodule

// ### tb/pack_extend_datapath_tb.sv
// self-checking bench for the pack and widen unit
`timescale 1ns/10ps
module pack_extend_datapath_tb;
  logic clk_i = 0, resetn_i = 0, issue_i, cond_pass_i, write_en_o, flags_write_o;
  logic [3:0] op_i, dest_index_i, write_index_o;
  logic [1:0] rotate_right_option_i;
  logic [4:0] shift_amount_i;
  logic [31:0] first_operand_register_i, second_operand_register_i, result_o;
  int err_total = 0, checked = 0;
  decode_model drv (.*);
  pack_extend_datapath dut (.*);
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] ref_v(logic [3:0] o, logic [1:0] n, logic [4:0] s, logic [31:0] x, y);
    logic [63:0] t = {y, y} >> 8 * n;
    int i = o - 2;
    logic g = i % 6 < 3;
    logic [15:0] l = {{8{g & t[7]}}, t[7:0]}, h = {{8{g & t[23]}}, t[23:16]};
    logic [31:0] w = i % 3 ? {{16{g & t[15]}}, t[15:0]} : {{24{g & t[7]}}, t[7:0]}, q = y << s;
    logic [63:0] p = {{32{y[31]}}, y} >> (s ? s : 6'd32);
    if (o < 2) return o ? {x[31:16], p[15:0]} : {q[31:16], x[15:0]};
    if (o > 13) return 32'h0;
    if (i % 3 == 2) w = {h, l};
    return i < 6 ? w : i % 3 == 2 ? {x[31:16] + h, x[15:0] + l} : x + w;
  endfunction
  task automatic run(logic [3:0] o, logic [1:0] n, logic [4:0] s, logic [31:0] x, y, logic c);
    drv.put(o, n, s, x, y, c);
    @(negedge clk_i);
    checked++;
    if ({write_en_o, flags_write_o, write_index_o, result_o} !==
        {c && o < 4'he, 1'b0, {1'b0, o[2:0]}, ref_v(o, n, s, x, y)}) begin
      err_total++;
      $display("ERROR %0t op %h got %h", $time, o, result_o);
    end
  endtask
  task automatic t_pack;
    for (int s = 0; s < 32; s = s * 2 + 1)
      for (int o = 0; o < 2; o++)
        run(o[3:0], 2'h0, s[4:0], 32'h1234abcd, 32'h87654321, 1'b1);
    $display("pack done");
  endtask
  task automatic t_widen;
    for (int o = 2; o < 16; o++)
      for (int n = 0; n < 4; n++) begin
        run(o[3:0], n[1:0], 5'h0, 32'hfffffff0, 32'h80ff7f01, n != 3);
        run(o[3:0], n[1:0], 5'h1f, 32'h00018000, 32'h7f80ff80, 1'b1);
      end
    $display("widen done");
  endtask
  task automatic t_idle;
    drv.idle(4'h0);
    @(negedge clk_i);
    checked++;
    if (write_en_o !== 1'b0) begin
      err_total++;
      $display("ERROR %0t write without issue", $time);
    end
    $display("idle done");
  endtask
  task end_of_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    resetn_i = 1;
    t_pack;
    t_widen;
    t_idle;
    end_of_test;
  end
  initial begin
    #5000;
    err_total++;
    end_of_test;
  end
endmodule
bind pack_extend_datapath pack_extend_assertions chk (.*);
